// ### dcfr_bus_model.sv
// CPU bus cycle source: one opcode fetch every clock.
// Assumes the bench sets the address and data of the coming cycles on the falling edge.
// Values are taken on the rising edge, so the design sees them one cycle later without a race.
`timescale 1ns/1ns
module dcfr_bus_model (
  input wire mclk, // Clock.
  input wire [15:0] addr_in, // Next address.
  input wire [7:0] data_in, // Next data.
  output reg [15:0] cpu_addr_bus = 16'h0000, // Bus address.
  output reg [7:0] cpu_data_bus = 8'h00, // Bus data.
  output reg bus_valid = 1'b0, // Cycle present.
  output reg opcode_fetch = 1'b0 // Fetch cycle.
);
  always @(posedge mclk) begin
    cpu_addr_bus <= addr_in;
    cpu_data_bus <= data_in;
    bus_valid <= 1'b1;
    opcode_fetch <= 1'b1;
  end
endmodule // dcfr_bus_model

// ### dcfr_debug_regs.v
// Debug module registers: two comparators, trace FIFO port, control, trigger, force reset.
// Assumes a CPU register port with one-cycle read and write strobes, and a host port.
`timescale 1ns/1ns
`include "dcfr_defines.vh"

module dcfr_debug_regs (
  input wire mclk, // Bus clock, 25 MHz.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire cpu_rd, // CPU register read strobe, one cycle.
  input wire cpu_wr, // CPU register write strobe, one cycle.
  input wire [3:0] cpu_addr, // CPU register offset.
  input wire [7:0] cpu_wdata, // CPU write data.
  output reg [7:0] cpu_rdata, // CPU read data, valid the cycle after cpu_rd.
  input wire host_wr, // Serial debug host memory write strobe.
  input wire [3:0] host_addr, // Host write offset.
  input wire [7:0] host_wdata, // Host write data.
  input wire mcu_secure, // MCU is secured.
  input wire [15:0] cpu_addr_bus, // Address of the current CPU bus cycle.
  input wire [7:0] cpu_data_bus, // Data of the current CPU bus cycle.
  input wire bus_valid, // A CPU bus cycle is present.
  input wire opcode_fetch, // Current bus cycle fetches an opcode.
  output wire [15:0] compare_a, // Comparator A value.
  output wire [15:0] compare_b, // Comparator B value.
  output wire run_active_flag, // Armed flag.
  output wire mcu_reset_req // System reset request, active high.
);

  reg [7:0] cmp_ah_q;
  reg [7:0] cmp_al_q;
  reg [7:0] cmp_bh_q;
  reg [7:0] cmp_bl_q;
  reg module_enable_q;
  reg run_active_q;
  reg run_active_flag_q;
  reg [3:0] trigger_mode_select_q;
  reg begin_trace_q;
  reg triggered_q;
  reg a_seen_q;
  reg [15:0] last_opcode_q;
  wire user_wr;
  wire event_only;
  wire wr_cmp_ok;
  wire ctrl_wr;
  wire low_rd;
  wire match_a;
  wire match_b;
  wire trig_hit;
  wire capture;
  wire [15:0] push_word;
  wire [15:0] head_word;
  wire fifo_full;
  wire run_done;
  wire fifo_clear;

  assign compare_a = {cmp_ah_q, cmp_al_q};
  assign compare_b = {cmp_bh_q, cmp_bl_q};
  assign run_active_flag = run_active_flag_q;
  assign event_only = (trigger_mode_select_q == `DCFR_TRG_EVENT_B) ||
                      (trigger_mode_select_q == `DCFR_TRG_A_THEN_EVENT_B);

  ////////////////////////////////////////////////////////////////////////
  // Write decode.
  assign user_wr = cpu_wr;
  assign wr_cmp_ok = user_wr && !run_active_q;
  assign ctrl_wr = user_wr && (cpu_addr == `DCFR_OFF_CONTROL);
  assign low_rd = cpu_rd && (cpu_addr == `DCFR_OFF_FIFO_LOW);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_ah_q <= `DCFR_CMP_RESET;
      cmp_al_q <= `DCFR_CMP_RESET;
      cmp_bh_q <= `DCFR_CMP_RESET;
      cmp_bl_q <= `DCFR_CMP_RESET;
      trigger_mode_select_q <= 4'h0;
      begin_trace_q <= 1'b0;
    end else if (wr_cmp_ok) begin
      case (cpu_addr)
        `DCFR_OFF_CMP_A_HIGH: cmp_ah_q <= cpu_wdata;
        `DCFR_OFF_CMP_A_LOW: cmp_al_q <= cpu_wdata;
        `DCFR_OFF_CMP_B_HIGH: cmp_bh_q <= cpu_wdata;
        `DCFR_OFF_CMP_B_LOW: cmp_bl_q <= cpu_wdata;
        `DCFR_OFF_TRIGGER: begin
          trigger_mode_select_q <= cpu_wdata[3:0];
          begin_trace_q <= cpu_wdata[6];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Comparators and trigger.
  assign match_a = bus_valid && (cpu_addr_bus == compare_a);
  assign match_b = bus_valid && (cpu_addr_bus == compare_b);

  reg trig_c;
  always @* begin
    case (trigger_mode_select_q)
      4'h0: trig_c = match_a;
      4'h1: trig_c = match_a || match_b;
      4'h2: trig_c = a_seen_q && match_b;
      4'h3: trig_c = match_b;
      4'h4: trig_c = a_seen_q && match_b;
      4'h5: trig_c = match_a && (cpu_data_bus == cmp_bl_q);
      4'h6: trig_c = match_a && (cpu_data_bus != cmp_bl_q);
      4'h7: trig_c = bus_valid && (cpu_addr_bus >= compare_a) && (cpu_addr_bus <= compare_b);
      4'h8: trig_c = bus_valid && ((cpu_addr_bus < compare_a) || (cpu_addr_bus > compare_b));
      default: trig_c = 1'b0;
    endcase
  end
  assign trig_hit = run_active_flag_q && trig_c;

  // Event-only modes store on every trigger; others store opcode addresses.
  // byte into low half
  assign push_word = event_only ? {`DCFR_ZERO_BYTE, cpu_data_bus} : cpu_addr_bus;
  assign capture = run_active_flag_q && (event_only ? trig_hit :
                   (opcode_fetch && bus_valid && (triggered_q || !begin_trace_q || trig_hit)));
  assign run_done = run_active_flag_q && fifo_full;
  assign fifo_clear = ctrl_wr && cpu_wdata[`DCFR_BIT_RUN_ACTIVE] && cpu_wdata[`DCFR_BIT_MODULE_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // Control and arm state.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      module_enable_q <= 1'b0;
      run_active_q <= 1'b0;
      run_active_flag_q <= 1'b0;
      triggered_q <= 1'b0;
      a_seen_q <= 1'b0;
      last_opcode_q <= 16'h0000;
    end else begin
      if (bus_valid && opcode_fetch) begin
        last_opcode_q <= cpu_addr_bus;
      end
      if (ctrl_wr) begin
        module_enable_q <= cpu_wdata[`DCFR_BIT_MODULE_ENABLE] && !mcu_secure;
        run_active_q <= cpu_wdata[`DCFR_BIT_RUN_ACTIVE] && cpu_wdata[`DCFR_BIT_MODULE_ENABLE] && !mcu_secure;
        run_active_flag_q <= cpu_wdata[`DCFR_BIT_RUN_ACTIVE] && cpu_wdata[`DCFR_BIT_MODULE_ENABLE] && !mcu_secure;
        triggered_q <= 1'b0;
        a_seen_q <= 1'b0;
      end else if (run_done) begin
        run_active_q <= 1'b0;
        run_active_flag_q <= 1'b0;
      end else if (run_active_flag_q) begin
        if (match_a) begin
          a_seen_q <= 1'b1;
        end
        if (trig_hit) begin
          triggered_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trace FIFO.
  dcfr_trace_fifo u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(fifo_clear),
    .push(capture),
    .push_word(push_word),
    .advance(low_rd && !run_active_flag_q),
    .profile_store(low_rd && !run_active_flag_q),
    .profile_word(last_opcode_q),
    .head_word(head_word),
    .full(fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero.
  // nine-byte user map
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rdata <= `DCFR_ZERO_BYTE;
    end else if (cpu_rd) begin
      case (cpu_addr)
        `DCFR_OFF_CMP_A_HIGH: cpu_rdata <= cmp_ah_q;
        `DCFR_OFF_CMP_A_LOW: cpu_rdata <= cmp_al_q;
        `DCFR_OFF_CMP_B_HIGH: cpu_rdata <= cmp_bh_q;
        `DCFR_OFF_CMP_B_LOW: cpu_rdata <= cmp_bl_q;
        `DCFR_OFF_FIFO_HIGH: cpu_rdata <= event_only ? `DCFR_ZERO_BYTE : head_word[15:8];
        `DCFR_OFF_FIFO_LOW: cpu_rdata <= head_word[7:0];
        `DCFR_OFF_CONTROL: cpu_rdata <= {module_enable_q, run_active_q, 6'h00};
        `DCFR_OFF_TRIGGER: cpu_rdata <= {1'b0, begin_trace_q, 2'h0, trigger_mode_select_q};
        `DCFR_OFF_STATUS: cpu_rdata <= {run_active_flag_q, triggered_q, fifo_full, 5'h00};
        default: cpu_rdata <= `DCFR_ZERO_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host-only force reset
  dcfr_host_reset u_host_reset (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .host_wr(host_wr && (host_addr == `DCFR_OFF_FORCE_RESET)),
    .host_wdata(host_wdata),
    .mcu_reset_req(mcu_reset_req)
  );

endmodule // dcfr_debug_regs

// ### dcfr_debug_regs_monitor.sv
// Assertions on the debug register block ports.
// Assumes one clock, mclk, and reset sys_rst, active high.
`timescale 1ns/1ns
module dcfr_debug_regs_monitor (
  input wire mclk, // Clock.
  input wire sys_rst, // Reset.
  input wire cpu_rd, // Read strobe.
  input wire cpu_wr, // Write strobe.
  input wire [3:0] cpu_addr, // Offset.
  input wire [7:0] cpu_wdata, // Write data.
  input wire [7:0] cpu_rdata, // Read data.
  input wire host_wr, // Host strobe.
  input wire [3:0] host_addr, // Host offset.
  input wire [7:0] host_wdata, // Host data.
  input wire mcu_secure, // Secured.
  input wire [15:0] compare_a, // Comparator A.
  input wire [15:0] compare_b, // Comparator B.
  input wire run_active_flag, // Armed.
  input wire mcu_reset_req // Reset request.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire fire = host_wr && host_addr == 4'h9 && host_wdata[0];
  wire ctl_wr = cpu_wr && cpu_addr == 4'h6;
  sequence s_fire;
    fire;
  endsequence
  sequence s_pulse;
    mcu_reset_req [*4] ##1 !mcu_reset_req;
  endsequence
  chk_reset_pulse: assert property (s_fire |=> s_pulse)
    else $error("reset pulse wrong");
  chk_reset_cause: assert property ($rose(mcu_reset_req) |-> $past(fire))
    else $error("reset without host write");
  chk_host_zero: assert property (host_wr && !host_wdata[0] && !mcu_reset_req |=> !mcu_reset_req)
    else $error("reset on zero write");
  chk_force_zero: assert property (cpu_rd && cpu_addr == 4'h9 |=> cpu_rdata == 8'h00)
    else $error("force reset read not zero");
  chk_cmp_locked: assert property (cpu_wr && cpu_addr < 4'h4 && run_active_flag
    |=> $stable(compare_a) && $stable(compare_b))
    else $error("comparator changed while armed");
  chk_cmp_a_high: assert property (cpu_wr && cpu_addr == 4'h0 && !run_active_flag
    |=> compare_a[15:8] == $past(cpu_wdata))
    else $error("comparator A high not written");
  chk_cmp_b_low: assert property (cpu_wr && cpu_addr == 4'h3 && !run_active_flag
    |=> compare_b[7:0] == $past(cpu_wdata))
    else $error("comparator B low not written");
  chk_arm_set: assert property (ctl_wr && cpu_wdata[7:6] == 2'b11 && !mcu_secure |=> run_active_flag)
    else $error("arm not set");
  chk_run_stop: assert property (ctl_wr && cpu_wdata[7:6] != 2'b11 |=> !run_active_flag)
    else $error("run not stopped");
  chk_secure_arm: assert property (ctl_wr && mcu_secure && !run_active_flag |=> !run_active_flag)
    else $error("armed while secure");
endmodule // dcfr_debug_regs_monitor
////////////////////////////////////////
bind dcfr_debug_regs dcfr_debug_regs_monitor i_mon (.mclk, .sys_rst, .cpu_rd, .cpu_wr, .cpu_addr,
  .cpu_wdata, .cpu_rdata, .host_wr, .host_addr, .host_wdata, .mcu_secure, .compare_a, .compare_b,
  .run_active_flag, .mcu_reset_req);

// ### dcfr_defines.vh
// Register offsets, field positions, reset values and mode codes for the debug
// compare, trace FIFO and host force-reset block.
// Assumes an 8-bit CPU register port and a separate host memory-write port.
`ifndef DCFR_DEFINES_VH
`define DCFR_DEFINES_VH

`define DCFR_OFF_CMP_A_HIGH 4'h0
`define DCFR_OFF_CMP_A_LOW 4'h1
`define DCFR_OFF_CMP_B_HIGH 4'h2
`define DCFR_OFF_CMP_B_LOW 4'h3
`define DCFR_OFF_FIFO_HIGH 4'h4
`define DCFR_OFF_FIFO_LOW 4'h5
`define DCFR_OFF_CONTROL 4'h6
`define DCFR_OFF_TRIGGER 4'h7
`define DCFR_OFF_STATUS 4'h8
`define DCFR_OFF_FORCE_RESET 4'h9

`define DCFR_BIT_MODULE_ENABLE 7
`define DCFR_BIT_RUN_ACTIVE 6
`define DCFR_BIT_FORCE_RESET 0

`define DCFR_CMP_RESET 8'h00
`define DCFR_CTRL_RESET 8'h00
`define DCFR_ZERO_BYTE 8'h00

`define DCFR_TRG_EVENT_B 4'h3
`define DCFR_TRG_A_THEN_EVENT_B 4'h4

`define DCFR_FIFO_DEPTH 8
`define DCFR_FIFO_AW 3

`define DCFR_RESET_PULSE_CYCLES 4'h4

`endif

// ### dcfr_host_reset.v
// Host force-reset register: accepts host memory writes only, drives a reset pulse.
// Assumes host writes arrive as a one-cycle strobe from the serial debug logic.
`timescale 1ns/1ns
`include "dcfr_defines.vh"

module dcfr_host_reset (
  input wire mclk, // Bus clock.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire host_wr, // Host write strobe to this register.
  input wire [7:0] host_wdata, // Host write data.
  output reg mcu_reset_req // System reset request, active high.
);

  reg [3:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
      mcu_reset_req <= 1'b0;
    end else begin
      if (host_wr && host_wdata[`DCFR_BIT_FORCE_RESET]) begin
        cnt_q <= `DCFR_RESET_PULSE_CYCLES;
        mcu_reset_req <= 1'b1;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        mcu_reset_req <= (cnt_q != 4'h1);
      end else begin
        mcu_reset_req <= 1'b0;
      end
    end
  end

endmodule // dcfr_host_reset

// ### dcfr_trace_fifo.v
// Eight-word trace FIFO storage with a read pointer and a profiling write path.
// Assumes the owner decides when to advance and what word to store.
`timescale 1ns/1ns
`include "dcfr_defines.vh"

module dcfr_trace_fifo (
  input wire mclk, // Bus clock.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire clear, // Empties the FIFO and rewinds the pointer.
  input wire push, // Stores push_word at the write slot.
  input wire [15:0] push_word, // Word to store.
  input wire advance, // Moves the read slot to the next word.
  input wire profile_store, // Stores profile_word at the read slot.
  input wire [15:0] profile_word, // Opcode address for profiling.
  output wire [15:0] head_word, // Word at the read slot.
  output wire full // All eight slots written since clear.
);

  reg [15:0] mem_q [0:`DCFR_FIFO_DEPTH-1];
  reg [`DCFR_FIFO_AW-1:0] rd_q;
  reg [`DCFR_FIFO_AW-1:0] wr_q;
  reg [`DCFR_FIFO_AW:0] cnt_q;
  integer i;

  assign head_word = mem_q[rd_q];
  assign full = cnt_q[`DCFR_FIFO_AW];

  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_q <= 3'h0;
      wr_q <= 3'h0;
      cnt_q <= 4'h0;
      for (i = 0; i < `DCFR_FIFO_DEPTH; i = i + 1) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (clear) begin
      rd_q <= 3'h0;
      wr_q <= 3'h0;
      cnt_q <= 4'h0;
    end else begin
      if (push && !full) begin
        mem_q[wr_q] <= push_word;
        wr_q <= wr_q + 3'h1;
        cnt_q <= cnt_q + 4'h1;
      end
      // eight-deep ring
      // The slot just left becomes the last, so it returns after eight reads.
      if (profile_store) begin
        mem_q[rd_q] <= profile_word;
      end
      if (advance) begin
        rd_q <= rd_q + 3'h1;
      end
    end
  end

endmodule // dcfr_trace_fifo

// ### tb.sv
// Self-checking bench for the debug register block.
// Assumes read data one cycle after the strobe.
`timescale 1ns/1ns
module tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg cpu_rd = 1'b0, cpu_wr = 1'b0, host_wr = 1'b0, mcu_secure = 1'b0;
  reg [3:0] cpu_addr = 4'h0, host_addr = 4'h0;
  reg [7:0] cpu_wdata = 8'h00, host_wdata = 8'h00, b_data = 8'h00, rv, hv;
  reg [15:0] b_addr = 16'h0000;
  wire [7:0] cpu_rdata, cpu_data_bus;
  wire [15:0] cpu_addr_bus, compare_a, compare_b;
  wire bus_valid, opcode_fetch, run_active_flag, mcu_reset_req;
  integer n_fail = 0, cmp_count = 0, i, m;
  always #20 mclk = ~mclk;
  dcfr_debug_regs i_dut (.mclk, .sys_rst, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata, .host_wr,
    .host_addr, .host_wdata, .mcu_secure, .cpu_addr_bus, .cpu_data_bus, .bus_valid, .opcode_fetch,
    .compare_a, .compare_b, .run_active_flag, .mcu_reset_req);
  dcfr_bus_model i_bus (.mclk, .addr_in(b_addr), .data_in(b_data), .cpu_addr_bus, .cpu_data_bus,
    .bus_valid, .opcode_fetch);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      @(negedge mclk);
      cpu_wr = 1'b1;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge mclk);
      cpu_wr = 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a);
    begin
      @(negedge mclk);
      cpu_rd = 1'b1;
      cpu_addr = a;
      @(negedge mclk);
      cpu_rd = 1'b0;
      rv = cpu_rdata;
    end
  endtask
  task wr_host(input [7:0] d);
    begin
      @(negedge mclk);
      host_wr = 1'b1;
      host_addr = 4'h9;
      host_wdata = d;
      @(negedge mclk);
      host_wr = 1'b0;
    end
  endtask
  task finish_test;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_fail = n_fail + 1;
    finish_test;
  end
  ////////////////////////////////////////
  initial begin
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      rd_reg(i[3:0]);
      chk(rv, 16'h0000);
      wr_reg(i[3:0], 8'h11 * (i[7:0] + 8'h01));
    end
    for (i = 0; i < 4; i = i + 1) begin
      rd_reg(i[3:0]);
      chk(rv, {8'h00, 8'h11 * (i[7:0] + 8'h01)});
    end
    chk(compare_a, 16'h1122);
    chk(compare_b, 16'h3344);
    wr_reg(4'h9, 8'h01);
    chk(mcu_reset_req, 1'b0);
    wr_host(8'h00);
    chk(mcu_reset_req, 1'b0);
    wr_host(8'h01);
    chk(mcu_reset_req, 1'b1);
    repeat (5) @(negedge mclk);
    chk(mcu_reset_req, 1'b0);
    rd_reg(4'h9);
    chk(rv, 16'h0000);
    rd_reg(4'hF);
    chk(rv, 16'h0000);
    for (i = 0; i < 16; i = i + 1) begin
      b_addr = 16'h2000 + i[15:0];
      repeat (2) @(negedge mclk);
      rd_reg(4'h4);
      hv = rv;
      rd_reg(4'h4);
      chk(rv, hv);
      rd_reg(4'h5);
      if (i >= 8) chk({hv, rv}, 16'h2000 + i[15:0] - 16'h0008);
    end
    wr_reg(4'h7, 8'h03);
    wr_reg(4'h6, 8'hC0);
    chk(run_active_flag, 1'b1);
    rd_reg(4'h6);
    chk(rv[7:6], 2'b11);
    rd_reg(4'h5);
    chk(rv, 16'h0008);
    rd_reg(4'h5);
    chk(rv, 16'h0008);
    wr_reg(4'h0, 8'h99);
    rd_reg(4'h0);
    chk(rv, 8'h11);
    wr_reg(4'h6, 8'h80);
    chk(run_active_flag, 1'b0);
    wr_reg(4'h6, 8'hC0);
    wr_reg(4'h6, 8'h40);
    chk(run_active_flag, 1'b0);
    mcu_secure = 1'b1;
    wr_reg(4'h6, 8'h80);
    rd_reg(4'h6);
    chk(rv[7], 1'b0);
    mcu_secure = 1'b0;
    for (m = 3; m < 5; m = m + 1) begin
      wr_reg(4'h7, m[7:0]);
      wr_reg(4'h6, 8'hC0);
      b_addr = 16'h1122;
      @(negedge mclk);
      for (i = 0; i < 8; i = i + 1) begin
        b_addr = 16'h3344;
        b_data = 8'hA0 + i[7:0] + m[7:0];
        @(negedge mclk);
      end
      b_addr = 16'h2000;
      for (i = 0; i < 50 && run_active_flag; i = i + 1) @(negedge mclk);
      chk(run_active_flag, 1'b0);
      wr_reg(4'h4, 8'hFF);
      wr_reg(4'h5, 8'hFF);
      for (i = 0; i < 8; i = i + 1) begin
        rd_reg(4'h4);
        chk(rv, 16'h0000);
        rd_reg(4'h5);
        chk(rv, {8'h00, 8'hA0 + i[7:0] + m[7:0]});
      end
    end
    finish_test;
  end
endmodule // tb
